// File: verilog/dma_cmd_pkg.sv
// Behaviour
// RQ1: Source codes 110/111 step -2/-4, single only
// RQ2: Decrementing source range stays within 1K
// RQ3: Bit 7 picks destination bus, APB/AHB
// RQ4: Bit 6 picks source bus, APB/AHB
// RQ5: Bit 5 enables AHB error response interrupt
// RQ6: Bit 4 error flag, write 0 clears
// RQ7: Bit 3 burst: one or four transfers
// RQ8: Bit 2 enables the finish interrupt
// RQ9: Bit 1 finish flag, write 0 clears
// RQ10: Bit 0 runs channel, self-clears when done
// RQ11: Software stops early, polls before reprogramming
// RQ12: Control bit 2 enables buffered-write error interrupt
// RQ13: Policy 00 buffers only bufferable writes
// RQ14: Policy 01 always buffers, 10 never
// RQ15: Status bit 0 set on buffered error
// RQ16: Status flag clears only on written 1
// RQ17: Steps 001/010/011 add 1/2/4 or 4/8/16
// RQ18: Width codes word, half, byte; APB needs word
// RQ19: Cycle count sets number of DMA cycles
// RQ20: Completion clears run, sets finish flag
// RQ21: Policy 11 behaves like policy 00
// RQ22: Reserved bridge bits read zero
package dma_cmd_pkg;
    // Register byte addresses
    localparam logic [7:0] OFF_CYC  = 8'h88;
    localparam logic [7:0] OFF_CMD  = 8'h8c;
    localparam logic [7:0] OFF_CTRL = 8'hc0;
    localparam logic [7:0] OFF_STAT = 8'hc4;
    // Command field positions
    localparam int CMD_RUN     = 0;
    localparam int CMD_FIN_FLG = 1;
    localparam int CMD_FIN_EN  = 2;
    localparam int CMD_BURST   = 3;
    localparam int CMD_ERR_FLG = 4;
    localparam int CMD_ERR_EN  = 5;
    localparam int CMD_SRC_AHB = 6;
    localparam int CMD_DST_AHB = 7;
    localparam int CMD_SRC_LO  = 8;
    localparam int CMD_DST_LO  = 12;
    localparam int CMD_WID_LO  = 20;
    localparam int CTRL_IRQ_EN = 2;
    localparam int STAT_ERR    = 0;
    localparam int HPROT_BUF   = 1;
    // Writable command bits, reset values
    localparam logic [31:0] CMD_RW_MASK = 32'h0f3f77ff;
    localparam logic [31:0] CMD_RESET   = 32'h00000000;
    localparam logic [23:0] CYC_RESET   = 24'h000000;
    localparam logic [2:0]  CTRL_RESET  = 3'h0;
    localparam logic [1:0]  BEAT_SINGLE = 2'h0;
    localparam logic [1:0]  BEAT_BURST  = 2'h3;
    localparam logic [23:0] CYC_ONE     = 24'h000001;
    // Write buffer policy codes
    localparam logic [1:0] POL_PROT   = 2'h0;
    localparam logic [1:0] POL_ALWAYS = 2'h1;
    localparam logic [1:0] POL_NEVER  = 2'h2;

    // Engine states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } eng_t;

    // Address step in two's complement for a step code
    function automatic logic [5:0] step_of(input logic [2:0] code,
                                           input logic       burst);
        logic [5:0] st;
        st = 6'h00;
        case (code)
            3'h1: st = burst ? 6'h04 : 6'h01;
            3'h2: st = burst ? 6'h08 : 6'h02;
            3'h3: st = burst ? 6'h10 : 6'h04;
            3'h5: st = burst ? 6'h00 : 6'h3f;
            3'h6: st = burst ? 6'h00 : 6'h3e;
            3'h7: st = burst ? 6'h00 : 6'h3c;
            default: st = 6'h00;
        endcase
        return st;
    endfunction
endpackage

// File: verilog/dma_cmd_bridge.sv
`timescale 1ns/100ps
module dma_cmd_bridge
    import dma_cmd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        xfer_done,
    input  wire logic        ahb_err,
    input  wire logic        ahb_wr_valid,
    input  wire logic [1:0]  hprot,
    input  wire logic        apb_buf_err,
    output logic             xfer_req,
    output logic             beat_last,
    output logic             src_is_ahb,
    output logic             dst_is_ahb,
    output logic             burst_on,
    output logic      [1:0]  xfer_width,
    output logic      [5:0]  src_step,
    output logic      [5:0]  dst_step,
    output logic             buf_write,
    output logic             channel_irq,
    output logic             bridge_irq
);

    typedef struct packed {
        logic [31:0] cmd_r;
        logic [23:0] cyc_r;
        logic [23:0] left_r;
        logic [1:0]  beat_r;
        logic [2:0]  ctrl_r;
        logic        stat_r;
        eng_t        state_r;
        logic [31:0] prdata_r;
        logic        pready_r;
        logic        pslverr_r;
        logic        xfer_req_r;
        logic        last_r;
        logic [5:0]  src_step_r;
        logic [5:0]  dst_step_r;
        logic        buf_wr_r;
        logic        chan_irq_r;
        logic        br_irq_r;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic   wr_fire;
    logic   fin_evt;
    logic   hit;
    logic [1:0] last_beat;

    // Write takes effect at the edge where pready is sampled high
    assign wr_fire = ce && psel && penable && pwrite && s_r.pready_r;
    assign hit = (paddr == OFF_CYC) || (paddr == OFF_CMD) ||
                 (paddr == OFF_CTRL) || (paddr == OFF_STAT);
    // Beats per DMA cycle follow the burst bit
    assign last_beat = s_r.cmd_r[CMD_BURST] ? BEAT_BURST : BEAT_SINGLE; // RQ7

    // Next state of bus slave, registers and channel engine
    always_comb begin
        s_nxt = s_r;
        fin_evt = 1'b0;
        // One wait state, then a one-cycle answer
        s_nxt.pready_r = 1'b0;
        s_nxt.pslverr_r = 1'b0;
        if (psel && penable && !s_r.pready_r) begin
            s_nxt.pready_r = 1'b1;
            s_nxt.pslverr_r = !hit;
            s_nxt.prdata_r = 32'h00000000;
            if (!pwrite) begin
                case (paddr)
                    OFF_CYC:  s_nxt.prdata_r = {8'h00, s_r.cyc_r};
                    OFF_CMD:  s_nxt.prdata_r = s_r.cmd_r;
                    OFF_CTRL: s_nxt.prdata_r = {29'h0, s_r.ctrl_r}; // RQ22
                    OFF_STAT: s_nxt.prdata_r = {31'h0, s_r.stat_r}; // RQ22
                    default:  s_nxt.prdata_r = 32'h00000000;
                endcase
            end
        end
        // Software writes
        if (wr_fire) begin
            case (paddr)
                OFF_CYC: s_nxt.cyc_r = pwdata[23:0]; // RQ19
                OFF_CMD: begin
                    s_nxt.cmd_r = pwdata & CMD_RW_MASK; // RQ18
                    // Flags: a written 0 clears, a written 1 keeps
                    s_nxt.cmd_r[CMD_ERR_FLG] = s_r.cmd_r[CMD_ERR_FLG] &&
                                               pwdata[CMD_ERR_FLG]; // RQ6
                    s_nxt.cmd_r[CMD_FIN_FLG] = s_r.cmd_r[CMD_FIN_FLG] &&
                                               pwdata[CMD_FIN_FLG]; // RQ9
                end
                OFF_CTRL: s_nxt.ctrl_r = pwdata[2:0]; // RQ22
                OFF_STAT: begin
                    if (pwdata[STAT_ERR]) begin
                        s_nxt.stat_r = 1'b0; // RQ16
                    end
                end
                default: s_nxt.stat_r = s_nxt.stat_r;
            endcase
        end
        // Hardware sets win over software clears
        if (apb_buf_err) begin
            s_nxt.stat_r = 1'b1; // RQ15
        end
        if (ahb_err && s_r.cmd_r[CMD_RUN] && s_r.cmd_r[CMD_ERR_EN]) begin
            s_nxt.cmd_r[CMD_ERR_FLG] = 1'b1; // RQ5
        end
        // Channel engine
        case (s_r.state_r)
            ST_IDLE: begin
                if (s_r.cmd_r[CMD_RUN]) begin
                    if (s_r.left_r != CYC_RESET) begin
                        s_nxt.state_r = ST_RUN; // Resume after pause
                    end else if (s_r.cyc_r != CYC_RESET) begin
                        s_nxt.left_r = s_r.cyc_r; // RQ19
                        s_nxt.beat_r = BEAT_SINGLE;
                        s_nxt.state_r = ST_RUN;
                    end else begin
                        fin_evt = 1'b1; // Zero cycles finish at once
                    end
                end
            end
            ST_RUN: begin
                if (!s_r.cmd_r[CMD_RUN]) begin
                    s_nxt.state_r = ST_IDLE; // Stopped, counts kept
                end else if (xfer_done) begin
                    if (s_r.beat_r >= last_beat) begin
                        s_nxt.beat_r = BEAT_SINGLE;
                        s_nxt.left_r = s_r.left_r - CYC_ONE;
                        if (s_r.left_r == CYC_ONE) begin
                            fin_evt = 1'b1;
                            s_nxt.state_r = ST_IDLE;
                        end
                    end else begin
                        s_nxt.beat_r = s_r.beat_r + 2'h1; // RQ7
                    end
                end
            end
            default: s_nxt.state_r = ST_IDLE;
        endcase
        // Completion clears run and raises the finish flag
        if (fin_evt) begin
            s_nxt.cmd_r[CMD_RUN] = 1'b0; // RQ10
            s_nxt.cmd_r[CMD_FIN_FLG] = 1'b1; // RQ20
        end
        // Datapath controls
        s_nxt.xfer_req_r = (s_nxt.state_r == ST_RUN) &&
                           s_nxt.cmd_r[CMD_RUN];
        s_nxt.last_r = (s_nxt.beat_r >= (s_nxt.cmd_r[CMD_BURST] ?
                        BEAT_BURST : BEAT_SINGLE)) &&
                       (s_nxt.left_r == CYC_ONE);
        s_nxt.src_step_r = step_of(s_nxt.cmd_r[CMD_SRC_LO +: 3],
                                   s_nxt.cmd_r[CMD_BURST]); // RQ1 RQ17
        s_nxt.dst_step_r = step_of(s_nxt.cmd_r[CMD_DST_LO +: 3],
                                   s_nxt.cmd_r[CMD_BURST]); // RQ17
        // Write buffer decision per AHB write
        s_nxt.buf_wr_r = 1'b0;
        if (ahb_wr_valid) begin
            case (s_r.ctrl_r[1:0])
                POL_ALWAYS: s_nxt.buf_wr_r = 1'b1; // RQ14
                POL_NEVER:  s_nxt.buf_wr_r = 1'b0; // RQ14
                POL_PROT:   s_nxt.buf_wr_r = hprot[HPROT_BUF]; // RQ13
                default:    s_nxt.buf_wr_r = hprot[HPROT_BUF]; // RQ21
            endcase
        end
        // Interrupt lines from flags and enables
        s_nxt.chan_irq_r = (s_r.cmd_r[CMD_ERR_FLG] &&
                            s_r.cmd_r[CMD_ERR_EN]) ||
                           (s_r.cmd_r[CMD_FIN_FLG] &&
                            s_r.cmd_r[CMD_FIN_EN]); // RQ8
        s_nxt.br_irq_r = s_r.stat_r && s_r.ctrl_r[CTRL_IRQ_EN]; // RQ12
    end

    // State register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{cmd_r: CMD_RESET, cyc_r: CYC_RESET, left_r: CYC_RESET,
                     beat_r: BEAT_SINGLE, ctrl_r: CTRL_RESET, stat_r: 1'b0,
                     state_r: ST_IDLE, prdata_r: 32'h00000000,
                     pready_r: 1'b0, pslverr_r: 1'b0, xfer_req_r: 1'b0,
                     last_r: 1'b0, src_step_r: 6'h00, dst_step_r: 6'h00,
                     buf_wr_r: 1'b0, chan_irq_r: 1'b0, br_irq_r: 1'b0};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign prdata      = s_r.prdata_r;
    assign pready      = s_r.pready_r;
    assign pslverr     = s_r.pslverr_r;
    assign xfer_req    = s_r.xfer_req_r;
    assign beat_last   = s_r.last_r;
    assign src_is_ahb  = s_r.cmd_r[CMD_SRC_AHB]; // RQ4
    assign dst_is_ahb  = s_r.cmd_r[CMD_DST_AHB]; // RQ3
    assign burst_on    = s_r.cmd_r[CMD_BURST]; // RQ7
    assign xfer_width  = s_r.cmd_r[CMD_WID_LO +: 2]; // RQ18
    assign src_step    = s_r.src_step_r;
    assign dst_step    = s_r.dst_step_r;
    assign buf_write   = s_r.buf_wr_r;
    assign channel_irq = s_r.chan_irq_r;
    assign bridge_irq  = s_r.br_irq_r;

    // Checks on the registered behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_fin_flag_set: assert property (ce && fin_evt |=> // RQ20
        s_r.cmd_r[CMD_FIN_FLG] && !s_r.cmd_r[CMD_RUN])
        else $error("finish did not set flag and clear run");
    a_run_autoclr: assert property (ce && s_r.state_r == ST_RUN && // RQ10
        s_r.cmd_r[CMD_RUN] && xfer_done && s_r.beat_r >= last_beat &&
        s_r.left_r == CYC_ONE |=> !s_r.cmd_r[CMD_RUN] ##1 !xfer_req)
        else $error("run bit not cleared after last cycle");
    a_err_flag_set: assert property (ce && ahb_err && // RQ5
        s_r.cmd_r[CMD_RUN] && s_r.cmd_r[CMD_ERR_EN] |=>
        s_r.cmd_r[CMD_ERR_FLG] ##1 (!ce || channel_irq))
        else $error("error flag or interrupt missing");
    a_err_disabled: assert property (!s_r.cmd_r[CMD_ERR_EN] && // RQ5
        !s_r.cmd_r[CMD_ERR_FLG] |=> !s_r.cmd_r[CMD_ERR_FLG])
        else $error("error flag set while disabled");
    a_err_w0_clear: assert property (wr_fire && paddr == OFF_CMD && // RQ6
        !pwdata[CMD_ERR_FLG] && !ahb_err |=> !s_r.cmd_r[CMD_ERR_FLG])
        else $error("error flag not cleared by written 0");
    a_fin_w0_clear: assert property (wr_fire && paddr == OFF_CMD && // RQ9
        !pwdata[CMD_FIN_FLG] && !fin_evt |=> !s_r.cmd_r[CMD_FIN_FLG])
        else $error("finish flag not cleared by written 0");
    a_stat_set: assert property (ce && apb_buf_err |=> s_r.stat_r) // RQ15
        else $error("buffered write error not recorded");
    a_stat_hold: assert property (s_r.stat_r && // RQ16
        !(wr_fire && paddr == OFF_STAT && pwdata[STAT_ERR]) |=> s_r.stat_r)
        else $error("status flag lost without written 1");
    a_stat_w1c: assert property (wr_fire && paddr == OFF_STAT && // RQ16
        pwdata[STAT_ERR] && !apb_buf_err |=> !s_r.stat_r)
        else $error("status flag not cleared by written 1");
    a_bridge_irq: assert property (ce |=> // RQ12
        bridge_irq == $past(s_r.stat_r && s_r.ctrl_r[CTRL_IRQ_EN]))
        else $error("bridge interrupt does not follow flag and enable");
    a_buf_never: assert property (ce && ahb_wr_valid && // RQ14
        s_r.ctrl_r[1:0] == POL_NEVER |=> !buf_write)
        else $error("write buffered under never policy");
    a_buf_prot: assert property (ce && ahb_wr_valid && // RQ13
        s_r.ctrl_r[0] == 1'b0 && s_r.ctrl_r[1] == 1'b0 |=>
        buf_write == $past(hprot[HPROT_BUF]))
        else $error("protection policy decision wrong");
    a_apb_answer: assert property (ce && psel && penable && // RQ22
        !pready && !pwrite && paddr == OFF_CTRL |=>
        pready && prdata[31:3] == 29'h0)
        else $error("control read late or reserved bits set");

    c_finish: cover property (ce && fin_evt && s_r.state_r == ST_RUN);
    c_error: cover property (ce && ahb_err && s_r.cmd_r[CMD_ERR_EN]);
    c_pause: cover property (s_r.state_r == ST_RUN && !s_r.cmd_r[CMD_RUN]);
    c_buf_err: cover property (bridge_irq);

endmodule // dma_cmd_bridge

// File: tb/dp_model.sv
`timescale 1ns/100ps
// Datapath stand-in: grants beats while asked, stalling at random
module dp_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic xfer_req,
    output logic      xfer_done
);
    logic [15:0] lfsr_r;

    // Never two beats in a row, so no beat lands after the last one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_r    <= 16'hace1;
            xfer_done <= 1'b0;
        end else begin
            lfsr_r    <= {lfsr_r[14:0],
                          lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
            xfer_done <= xfer_req & ~xfer_done & lfsr_r[0];
        end
    end
endmodule // dp_model

// File: tb/apb_bridge_dma_command_and_write_buffer_test.sv
`timescale 1ns/100ps
module apb_bridge_dma_command_and_write_buffer_test;
    import dma_cmd_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, ahb_err = 1'b0, ahb_wr_valid = 1'b0;
    logic        apb_buf_err = 1'b0, pready, pslverr, xfer_done, xfer_req;
    logic        beat_last, src_is_ahb, dst_is_ahb, burst_on, buf_write;
    logic        channel_irq, bridge_irq, err, ce = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic [1:0]  hprot = 2'h0, xfer_width;
    logic [5:0]  src_step, dst_step;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'd54985;
    int          miscompares = 0, compares = 0, beats = 0;

    dma_cmd_bridge i_dma_cmd_bridge (.pclk, .presetn, .ce, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .xfer_done, .ahb_err, .ahb_wr_valid, .hprot, .apb_buf_err, .xfer_req,
        .beat_last, .src_is_ahb, .dst_is_ahb, .burst_on, .xfer_width,
        .src_step, .dst_step, .buf_write, .channel_irq, .bridge_irq);
    dp_model i_dp_model (.pclk, .presetn, .xfer_req, .xfer_done);

    always #25 pclk = ~pclk;
    // Beats granted while the channel asks
    always @(posedge pclk) if (xfer_done === 1'b1 && xfer_req === 1'b1) beats++;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected address step for a step code
    function automatic logic [5:0] xs(input logic [2:0] c, input logic b);
        logic [5:0] m;
        m = (c[1:0] == 2'h0) ? 6'h00 : 6'h01 << (c[1:0] - 2'h1);
        if (c[2]) return b ? 6'h00 : -m;
        return b ? m << 2 : m;
    endfunction

    task final_report;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Sample pready at the rising edge; answer taken at that edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task pulse_wait(input int n);
        @(posedge pclk);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    initial begin
        logic [31:0] c;
        logic        b;
        int          n;
        int          k;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, reserved bits, unmapped place
        rdchk(OFF_CTRL, 32'h0);
        rdchk(OFF_CMD, 32'h0);
        apb(1'b1, OFF_CTRL, 32'hffffffff);
        rdchk(OFF_CTRL, 32'h7);
        apb(1'b1, OFF_STAT, 32'hffffffff);
        rdchk(OFF_STAT, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // Clock enable low: an error pulse must not be recorded
        ce <= 1'b0;
        apb_buf_err <= 1'b1;
        @(posedge pclk);
        apb_buf_err <= 1'b0;
        @(posedge pclk);
        ce <= 1'b1;
        rdchk(OFF_STAT, 32'h0);
        $display("test reset done");
        // Command fields over every step code, single and burst
        for (int i = 0; i < 16; i++) begin
            c = rnd() & CMD_RW_MASK & 32'hffff88e4;
            c = c | {i[3], 3'h0} | {i[2:0], 8'h00} | {~i[2:0], 12'h000};
            apb(1'b1, OFF_CMD, c);
            rdchk(OFF_CMD, c);
            chk({dst_is_ahb, src_is_ahb, burst_on, xfer_width, src_step,
                 dst_step}, {c[7], c[6], c[3], c[21:20], xs(c[10:8], c[3]),
                 xs(c[14:12], c[3])});
        end
        $display("test fields done");
        // Runs: burst, single, single with error interrupt off
        for (int i = 0; i < 3; i++) begin
            n = 3 + int'(rnd() & 32'h3);
            b = (i == 0);
            beats = 0;
            apb(1'b1, OFF_CYC, n);
            apb(1'b1, OFF_CMD, {26'h0, i != 2, 1'b0, b, 3'h5});
            ahb_err <= 1'b1;
            @(posedge pclk);
            ahb_err <= 1'b0;
            k = 0;
            do begin
                apb(1'b0, OFF_CMD, 32'h0);
                k++;
            end while (rd[0] !== 1'b0 && k < 40);
            if (rd[0] !== 1'b0) begin
                miscompares++;
                final_report();
            end
            chk(beats, n * (b ? 4 : 1));
            chk(rd[5:0], {i != 2, i != 2, b, 3'h6});
            chk(channel_irq, 32'h1);
            apb(1'b1, OFF_CMD, {26'h0, 2'b11, b, 3'h4});
            pulse_wait(1);
            chk(channel_irq, i != 2);
            apb(1'b1, OFF_CMD, 32'h0);
            rdchk(OFF_CMD, 32'h0);
            chk(channel_irq, 32'h0);
        end
        $display("test channel done");
        // Write buffer policy against every protection attribute
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, OFF_CTRL, {30'h0, i[3:2]});
            ahb_wr_valid <= 1'b1;
            hprot <= i[1:0];
            @(posedge pclk);
            ahb_wr_valid <= 1'b0;
            n = 0;
            repeat (3) begin
                @(negedge pclk);
                if (buf_write === 1'b1) n++;
            end
            chk(n, i[3:2] != 2 && (i[3:2] == 1 || i[1]));
        end
        $display("test buffer done");
        // Buffered write error with interrupt off and on
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, OFF_CTRL, {29'h0, i[0], 2'h0});
            apb_buf_err <= 1'b1;
            @(posedge pclk);
            apb_buf_err <= 1'b0;
            pulse_wait(2);
            chk(bridge_irq, i);
            rdchk(OFF_STAT, 32'h1);
            apb(1'b1, OFF_STAT, 32'h0);
            rdchk(OFF_STAT, 32'h1);
            apb(1'b1, OFF_STAT, 32'h1);
            rdchk(OFF_STAT, 32'h0);
            chk(bridge_irq, 32'h0);
        end
        $display("test status done");
        final_report();
    end
endmodule // apb_bridge_dma_command_and_write_buffer_test
